// ==== stmr_pkg.sv ====
// Constants, field layouts and carrier types of the sixteen-bit timer/counter.
// Assumes a single 40 MHz clock and an AHB-Lite slave port with word-only access.
// Behaviour
// [R1] One sixteen-bit counter for interval or clock use
// [R2] Source, gate, sync bits select four modes
// [R3] Timer and gated modes count instruction-cycle ticks
// [R4] Counter modes count the external count input
// [R5] Source bit 1 picks external rising edges
// [R6] Sync bit 2 matters only for external source
// [R7] Synchronisation stage sits after the prescaler
// [R8] Gate bit 6 works only with internal source
// [R9] Prescale bits 5-4 divide by 1/8/64/256
// [R10] Run bit 15 starts and stops counting
// [R11] Idle-stop bit 13 halts counting in idle
// [R12] Unimplemented control bits read as zero
// [R13] Slow crystal may drive asynchronous counting
// [R14] Period match clears counter and flags event
// [R15] Gated counting only while gate high, event on fall
package stmr_pkg;

	// Clock and external source timing
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 25;
	localparam int unsigned LP_XTAL_HZ      = 32767;
	localparam int unsigned XTAL_PERIOD_CYC = CLK_HZ / LP_XTAL_HZ;
	localparam int unsigned MIN_EXT_CYC     = 4;

	// Register byte offsets, low address bits only
	localparam int unsigned ADDR_DEC_W = 8;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNT   = 8'h04;
	localparam logic [7:0] OFS_PERIOD  = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0c;
	localparam logic [7:0] OFS_CLEAR   = 8'h10;
	localparam logic [7:0] OFS_ENABLE  = 8'h14;

	// Control field positions
	localparam int unsigned BIT_RUN   = 15;
	localparam int unsigned BIT_IDLE  = 13;
	localparam int unsigned BIT_GATE  = 6;
	localparam int unsigned BIT_PS_LO = 4;
	localparam int unsigned BIT_SYNC  = 2;
	localparam int unsigned BIT_SRC   = 1;
	localparam logic [15:0] CTRL_IMPL_MASK = 16'ha076;

	// Event bits of status, clear and enable
	localparam int unsigned EV_W        = 2;
	localparam int unsigned EV_MATCH    = 0;
	localparam int unsigned EV_GATE_END = 1;

	// Prescale codes
	localparam logic [1:0] PS_1   = 2'h0;
	localparam logic [1:0] PS_8   = 2'h1;
	localparam logic [1:0] PS_64  = 2'h2;
	localparam logic [1:0] PS_256 = 2'h3;

	// Bus encodings and register reset values
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'h0;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;

	typedef struct packed {
		logic       run_enable;
		logic       idle_stop;
		logic       gate_accumulate_enable;
		logic [1:0] prescale_select;
		logic       external_sync_select;
		logic       clock_source_select;
	} stmr_ctrl_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} stmr_aphase_t;

	localparam stmr_ctrl_t CTRL_RESET = '0;

	// Division ratio of a prescale code
	function automatic logic [8:0] stmr_ratio(input logic [1:0] sel);
		unique case (sel)
			PS_1:    stmr_ratio = 9'h001;
			PS_8:    stmr_ratio = 9'h008;
			PS_64:   stmr_ratio = 9'h040;
			default: stmr_ratio = 9'h100;
		endcase
	endfunction

	// Control fields placed at their word positions
	function automatic logic [15:0] stmr_ctrl_word(input stmr_ctrl_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[BIT_RUN]              = c.run_enable;
		w[BIT_IDLE]             = c.idle_stop;
		w[BIT_GATE]             = c.gate_accumulate_enable;
		w[BIT_PS_LO +: 2]       = c.prescale_select;
		w[BIT_SYNC]             = c.external_sync_select;
		w[BIT_SRC]              = c.clock_source_select;
		stmr_ctrl_word = w;
	endfunction

endpackage

// ==== stmr_prescaler.sv ====
// Input prescaler of the timer: divides a tick stream by 1, 8, 64 or 256.
// Assumes ticks and clear come from logic on the same clock.
`timescale 1ns/1ps
module stmr_prescaler #(
	parameter int unsigned CNT_W = 8
) (
	input  wire logic       ref_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       tick_i,
	input  wire logic [1:0] sel_i,
	input  wire logic       clr_i,
	output logic            tick_o
);

	logic [CNT_W-1:0] cnt_reg;
	logic [8:0]       last;

	// Counter must hold the largest ratio minus one
	if (CNT_W < 8) begin : g_chk
		$error("stmr_prescaler: CNT_W below 8 cannot reach 1:256");
	end

	assign last = stmr_pkg::stmr_ratio(sel_i) - 9'h001;

	// Divider; clear drops any partial count
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (clr_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (tick_i) begin
			if (9'(cnt_reg) >= last) begin // [R9]
				cnt_reg <= '0;
				tick_o  <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
				tick_o  <= 1'b0;
			end
		end else begin
			tick_o <= 1'b0;
		end
	end

endmodule

// ==== stmr_top.sv ====
// Sixteen-bit timer/counter with period match, gate event and interrupt.
// Assumes AHB-Lite single word transfers and pins that are asynchronous.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module stmr_top #(
	parameter int unsigned CNT_W = 16,
	parameter int unsigned PS_W  = 8
) (
	input  wire logic        ref_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        ext_count_i,
	input  wire logic        gate_i,
	input  wire logic        idle_i,
	output logic             irq_o
);

	// Width and clock rate the logic can serve
	if (CNT_W != 16) begin : g_chk_cnt
		$error("stmr_top: counter is defined as sixteen bits");
	end
	if (stmr_pkg::XTAL_PERIOD_CYC < stmr_pkg::MIN_EXT_CYC) begin : g_chk_clk
		$error("stmr_top: clock too slow to sample the crystal");
	end

	stmr_pkg::stmr_ctrl_t   ctrl_reg;
	stmr_pkg::stmr_aphase_t ap_reg;
	logic [CNT_W-1:0]       count_reg;
	logic [CNT_W-1:0]       period_reg;
	logic [stmr_pkg::EV_W-1:0] status_reg;
	logic [stmr_pkg::EV_W-1:0] enable_reg;
	logic [stmr_pkg::EV_W-1:0] ev_set;
	logic [stmr_pkg::EV_W-1:0] ev_clr;
	logic ext_meta_reg;
	logic ext_sync_reg;
	logic ext_prev_reg;
	logic gate_meta_reg;
	logic gate_sync_reg;
	logic gate_prev_reg;
	logic ps_sync_reg;
	logic ext_rise;
	logic gate_fall;
	logic gated_mode;
	logic run_act;
	logic ps_in_tick;
	logic ps_tick;
	logic ps_clr;
	logic count_tick;
	logic period_hit;
	logic addr_take;
	logic wr_act;
	logic wr_ctrl;
	logic wr_count;
	logic [7:0] wr_addr;

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext_meta_reg  <= 1'b0;
			ext_sync_reg  <= 1'b0;
			ext_prev_reg  <= 1'b0;
			gate_meta_reg <= 1'b0;
			gate_sync_reg <= 1'b0;
			gate_prev_reg <= 1'b0;
		end else begin
			ext_meta_reg  <= ext_count_i;
			ext_sync_reg  <= ext_meta_reg;
			ext_prev_reg  <= ext_sync_reg;
			gate_meta_reg <= gate_i;
			gate_sync_reg <= gate_meta_reg;
			gate_prev_reg <= gate_sync_reg;
		end
	end

	// Edges of the cleaned pins
	assign ext_rise  = ext_sync_reg & ~ext_prev_reg; // [R5]
	assign gate_fall = gate_prev_reg & ~gate_sync_reg;

	// Mode decode from source and gate bits
	assign gated_mode = ~ctrl_reg.clock_source_select & ctrl_reg.gate_accumulate_enable; // [R2] [R8]

	// Idle only halts when software asked for it
	assign run_act = ctrl_reg.run_enable & ~(ctrl_reg.idle_stop & idle_i); // [R10] [R11]

	// Input tick: instruction cycle is every clock here, pin edge otherwise
	always_comb begin
		if (ctrl_reg.clock_source_select) begin
			ps_in_tick = ext_rise & run_act; // [R4] [R13]
		end else if (gated_mode) begin
			ps_in_tick = gate_sync_reg & run_act; // [R15]
		end else begin
			ps_in_tick = run_act; // [R3]
		end
	end

	// Partial prescale is dropped on control or count writes
	assign ps_clr = wr_ctrl | wr_count;

	stmr_prescaler #(
		.CNT_W (PS_W)
	) u_prescaler (
		.ref_clk_i (ref_clk_i),
		.arst_n_i  (arst_n_i),
		.tick_i    (ps_in_tick),
		.sel_i     (ctrl_reg.prescale_select),
		.clr_i     (ps_clr),
		.tick_o    (ps_tick)
	);

	// Resync stage after the divider costs one cycle of latency
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ps_sync_reg <= 1'b0;
		end else begin
			ps_sync_reg <= ps_tick; // [R7]
		end
	end

	// Sync select only steers the external path
	always_comb begin
		if (ctrl_reg.clock_source_select && ctrl_reg.external_sync_select) begin
			count_tick = ps_sync_reg & run_act; // [R6] [R7]
		end else begin
			count_tick = ps_tick & run_act; // [R6]
		end
	end

	assign period_hit = count_tick && (count_reg == period_reg);

	// Sixteen-bit counter with period wrap; software load wins
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_reg <= stmr_pkg::COUNT_RESET;
		end else if (wr_count) begin
			count_reg <= hwdata_i[CNT_W-1:0];
		end else if (period_hit) begin
			count_reg <= stmr_pkg::COUNT_RESET; // [R14]
		end else if (count_tick) begin
			count_reg <= count_reg + 1'b1; // [R1]
		end
	end

	// Events; gate end only counts while the gated timer runs
	always_comb begin
		ev_set = '0;
		ev_set[stmr_pkg::EV_MATCH]    = period_hit; // [R14]
		ev_set[stmr_pkg::EV_GATE_END] = gated_mode & run_act & gate_fall; // [R15]
	end

	// Address phase capture; only whole-word transfers are acted on
	assign addr_take = hsel_i & htrans_i[1] & hready_i;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ap_reg <= '0;
		end else if (hready_i) begin
			ap_reg.valid <= addr_take && (hsize_i == stmr_pkg::HSIZE_WORD);
			ap_reg.write <= hwrite_i;
			ap_reg.addr  <= haddr_i[stmr_pkg::ADDR_DEC_W-1:0];
		end
	end

	// Write decode in the data phase
	assign wr_act   = ap_reg.valid & ap_reg.write;
	assign wr_addr  = ap_reg.addr;
	assign wr_ctrl  = wr_act && (wr_addr == stmr_pkg::OFS_CONTROL);
	assign wr_count = wr_act && (wr_addr == stmr_pkg::OFS_COUNT);

	// Clear strobe of the write-only clear register
	always_comb begin
		ev_clr = '0;
		if (wr_act && (wr_addr == stmr_pkg::OFS_CLEAR)) begin
			ev_clr = hwdata_i[stmr_pkg::EV_W-1:0];
		end
	end

	// Control, period and enable registers
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg   <= stmr_pkg::CTRL_RESET;
			period_reg <= stmr_pkg::PERIOD_RESET;
			enable_reg <= '0;
		end else if (wr_act) begin
			if (wr_ctrl) begin
				ctrl_reg.run_enable             <= hwdata_i[stmr_pkg::BIT_RUN];
				ctrl_reg.idle_stop              <= hwdata_i[stmr_pkg::BIT_IDLE];
				ctrl_reg.gate_accumulate_enable <= hwdata_i[stmr_pkg::BIT_GATE];
				ctrl_reg.prescale_select        <= hwdata_i[stmr_pkg::BIT_PS_LO +: 2];
				ctrl_reg.external_sync_select   <= hwdata_i[stmr_pkg::BIT_SYNC];
				ctrl_reg.clock_source_select    <= hwdata_i[stmr_pkg::BIT_SRC];
			end
			if (wr_addr == stmr_pkg::OFS_PERIOD) begin
				period_reg <= hwdata_i[CNT_W-1:0];
			end
			if (wr_addr == stmr_pkg::OFS_ENABLE) begin
				enable_reg <= hwdata_i[stmr_pkg::EV_W-1:0];
			end
		end
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~ev_clr) | ev_set;
		end
	end

	// Level interrupt, one cycle behind the status bit
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_reg & enable_reg);
		end
	end

	// Read data registered at the address phase so it stands in the data phase
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (addr_take && !hwrite_i && (hsize_i == stmr_pkg::HSIZE_WORD)) begin
			unique case (haddr_i[stmr_pkg::ADDR_DEC_W-1:0])
				stmr_pkg::OFS_CONTROL: hrdata_o <= {16'h0000, stmr_pkg::stmr_ctrl_word(ctrl_reg)}; // [R12]
				stmr_pkg::OFS_COUNT:   hrdata_o <= {16'h0000, count_reg};
				stmr_pkg::OFS_PERIOD:  hrdata_o <= {16'h0000, period_reg};
				stmr_pkg::OFS_STATUS:  hrdata_o <= {30'h0000_0000, status_reg};
				stmr_pkg::OFS_ENABLE:  hrdata_o <= {30'h0000_0000, enable_reg};
				default:               hrdata_o <= 32'h0000_0000;
			endcase
		end else begin
			hrdata_o <= 32'h0000_0000;
		end
	end

	// Zero-wait slave that always answers OKAY
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hreadyout_o <= 1'b1;
			hresp_o     <= stmr_pkg::HRESP_OKAY;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o     <= stmr_pkg::HRESP_OKAY;
		end
	end

	// Checks next to the logic they guard
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence s_rd_ctrl;
		addr_take && !hwrite_i && (haddr_i[7:0] == stmr_pkg::OFS_CONTROL);
	endsequence

	sequence s_gate_fall;
		gated_mode && run_act && gate_prev_reg && !gate_sync_reg;
	endsequence

	sequence s_sync_tick;
		ps_tick && ctrl_reg.clock_source_select && ctrl_reg.external_sync_select;
	endsequence

	a_wrap_zero: assert property (period_hit && !wr_count |=> // [R14]
		(count_reg == 16'h0000) && status_reg[stmr_pkg::EV_MATCH])
		else $error("counter did not wrap with match flag");

	a_step_one: assert property (count_tick && !period_hit && !wr_count |=> // [R1]
		count_reg == $past(count_reg) + 16'h0001)
		else $error("counter did not step by one");

	a_stop_hold: assert property (!ctrl_reg.run_enable && !wr_count |=> $stable(count_reg)) // [R10]
		else $error("stopped counter moved");

	a_idle_halt: assert property (ctrl_reg.idle_stop && idle_i |-> !count_tick && !ps_in_tick) // [R11]
		else $error("counter ticked in idle with stop set");

	a_int_source: assert property (run_act && !ctrl_reg.clock_source_select && // [R3]
		!ctrl_reg.gate_accumulate_enable |-> ps_in_tick)
		else $error("internal source missed a cycle");

	a_ext_edge: assert property (ctrl_reg.clock_source_select |-> ps_in_tick == (ext_rise && run_act)) // [R4]
		else $error("external source tick mismatch");

	a_gate_block: assert property (gated_mode && !gate_sync_reg |-> !ps_in_tick) // [R15]
		else $error("gated timer counted with gate low");

	a_gate_event: assert property (s_gate_fall |=> status_reg[stmr_pkg::EV_GATE_END]) // [R15]
		else $error("gate end event missing");

	a_sync_delay: assert property (s_sync_tick ##1 run_act |-> count_tick) // [R7]
		else $error("synchronised tick not one cycle after divider");

	a_async_direct: assert property (ps_tick && run_act && ctrl_reg.clock_source_select && // [R6]
		!ctrl_reg.external_sync_select |-> count_tick)
		else $error("unsynchronised tick delayed");

	a_prescale_one: assert property (ps_in_tick && !ps_clr && // [R9]
		ctrl_reg.prescale_select == stmr_pkg::PS_1 |=> ps_tick)
		else $error("undivided prescale lost a tick");

	a_ctrl_zero: assert property (s_rd_ctrl |=> (hrdata_o[15:0] & ~stmr_pkg::CTRL_IMPL_MASK) == 16'h0000 // [R12]
		&& hrdata_o[31:16] == 16'h0000)
		else $error("unimplemented control bits read nonzero");

	a_irq_level: assert property (|(status_reg & enable_reg) |=> irq_o) // [R14]
		else $error("interrupt not raised for enabled status");

	// Sticky flag semantics; a lost flag would silently swallow an interrupt
	a_status_hold: assert property (status_reg[stmr_pkg::EV_MATCH] && !ev_clr[stmr_pkg::EV_MATCH] |=> // [R14]
		status_reg[stmr_pkg::EV_MATCH])
		else $error("match flag lost without a clear");

	a_clear_drop: assert property (ev_clr[stmr_pkg::EV_MATCH] && !ev_set[stmr_pkg::EV_MATCH] |=> // [R14]
		!status_reg[stmr_pkg::EV_MATCH])
		else $error("match flag survived its clear");

	a_irq_quiet: assert property (!(|(status_reg & enable_reg)) |=> !irq_o) // [R14]
		else $error("interrupt raised without enabled status");

	// Gate bit must not block pin edges once the external source is chosen
	a_gate_ignore: assert property (ctrl_reg.clock_source_select && ctrl_reg.gate_accumulate_enable && // [R8]
		!gate_sync_reg && ext_rise && run_act |-> ps_in_tick)
		else $error("gate bit blocked the external source");

	// Software load lands whole in the counter
	a_count_load: assert property (wr_count |=> {16'h0000, count_reg} == ($past(hwdata_i) & 32'h0000_ffff)) // [R1]
		else $error("count load lost data");

endmodule

// ==== stmr_ext_src.sv ====
// Model of the far side: an external count pin or slow crystal sending bursts.
// Assumes the bench starts a burst only while busy_o is low; the pin rests low between bursts.
`timescale 1ns/1ps
module stmr_ext_src (
	input  wire logic        ref_clk_i,
	input  wire logic        start_i,
	input  wire logic [7:0]  pulses_i,
	input  wire logic [15:0] half_i,
	output logic             ext_count_o,
	output logic             busy_o
);
	logic [7:0]  left_reg;
	logic [15:0] cnt_reg;

	// Idle source: clock stands still, low
	initial begin
		ext_count_o = 1'b0;
		busy_o      = 1'b0;
		left_reg    = 8'h00;
		cnt_reg     = 16'h0000;
	end

	// Burst of whole pulses; half period from the bench, never below one clock
	always @(posedge ref_clk_i) begin
		if (start_i && !busy_o) begin
			left_reg    <= pulses_i;
			cnt_reg     <= half_i;
			busy_o      <= (pulses_i != 8'h00);
			ext_count_o <= 1'b0;
		end else if (busy_o) begin
			if (cnt_reg > 16'h0001) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end else begin
				cnt_reg     <= half_i;
				ext_count_o <= ~ext_count_o;
				if (ext_count_o) begin
					left_reg <= left_reg - 8'h01;
					busy_o   <= (left_reg > 8'h01);
				end
			end
		end
	end
endmodule

// ==== stmr_top_bench.sv ====
// Self-checking bench of the timer/counter: AHB-Lite master, scoreboard queue, pulse source.
// Assumes zero-wait-state slave answers; hready is looped back from hreadyout.
`timescale 1ns/1ps
module stmr_top_bench;
	typedef struct packed {
		logic [31:0] e;
		logic [31:0] m;
	} stmr_exp_t;

	logic        clk, rst_n, hsel, hwrite, ext, gate, idle, start, busy, rd_dp, irq, hrdy, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize, sz;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [7:0]  npul;
	logic [15:0] half;
	int          fails, checks, seed, k, r;
	stmr_exp_t   expq[$];
	stmr_exp_t   cur;

	stmr_top uut (.ref_clk_i(clk), .arst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
		.hreadyout_o(hrdy), .hresp_o(hresp), .ext_count_i(ext), .gate_i(gate), .idle_i(idle), .irq_o(irq));

	stmr_ext_src src (.ref_clk_i(clk), .start_i(start), .pulses_i(npul), .half_i(half),
		.ext_count_o(ext), .busy_o(busy));

	// Clock of 25 ns
	always #12.5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic hang;
		fails++;
		$display("BAD %0t: timeout", $time);
		final_report;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One single transfer of size sz; a read notes its expectation for the monitor
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= sz;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		if (!w) expq.push_back('{d, m});
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 100);
		rd_dp <= 1'b0;
		if (n >= 100) hang;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, e, m);
	endtask

	// Burst from the far side, then time for the synchroniser to settle
	task automatic pulses(input logic [7:0] n, input logic [15:0] h);
		int t;
		t = 0;
		start <= 1'b1;
		npul <= n;
		half <= h;
		@(posedge clk);
		start <= 1'b0;
		do begin
			@(posedge clk);
			t++;
		end while (busy === 1'b1 && t < 60000);
		if (t >= 60000) hang;
		cyc(8);
	endtask

	// Control word laid out bit by bit, independent of the design's helpers
	function automatic logic [31:0] cw(input logic run, idl, gt, input logic [1:0] ps, input logic sy, sc);
		cw = {16'h0, run, 1'b0, idl, 6'h0, gt, ps, 1'b0, sy, sc, 1'b0};
	endfunction

	// Scoreboard: read data lands in the data phase, checked against the oldest note
	always @(posedge clk) begin
		if (rd_dp && expq.size() > 0) begin
			cur = expq.pop_front();
			check(hrdata & cur.m, cur.e & cur.m);
		end
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		sz = stmr_pkg::HSIZE_WORD;
		hwdata = 32'h0;
		gate = 1'b0;
		idle = 1'b0;
		start = 1'b0;
		npul = 8'h00;
		half = 16'h0002;
		rd_dp = 1'b0;
		fails = 0;
		checks = 0;
		seed = 32'hafc0;
		cyc(4);
		rst_n <= 1'b1;
		cyc(1);
		check({29'h0, hrdy, hresp, irq}, 32'h4);
		rd(stmr_pkg::OFS_CONTROL, 32'h0, '1);
		rd(stmr_pkg::OFS_COUNT, 32'h0, '1);
		rd(stmr_pkg::OFS_PERIOD, 32'hffff, '1);
		rd(stmr_pkg::OFS_STATUS, 32'h0, '1);
		rd(stmr_pkg::OFS_ENABLE, 32'h0, '1);
		wr(stmr_pkg::OFS_CONTROL, 32'hffff5f89);
		rd(stmr_pkg::OFS_CONTROL, 32'h0, '1);
		wr(stmr_pkg::OFS_CONTROL, 32'hffff2076);
		rd(stmr_pkg::OFS_CONTROL, 32'h2076, '1);
		v = $random(seed);
		wr(stmr_pkg::OFS_COUNT, v);
		rd(stmr_pkg::OFS_COUNT, {16'h0, v[15:0]}, '1);
		wr(8'h18, v);
		rd(8'h18, 32'h0, '1);
		// Sub-word transfers have no effect and read back zero
		sz = 3'h0;
		wr(stmr_pkg::OFS_PERIOD, v);
		rd(stmr_pkg::OFS_PERIOD, 32'h0, '1);
		sz = stmr_pkg::HSIZE_WORD;
		rd(stmr_pkg::OFS_PERIOD, 32'hffff, '1);
		wr(stmr_pkg::OFS_STATUS, 32'h3);
		rd(stmr_pkg::OFS_STATUS, 32'h0, '1);
		$display("done: registers");
		// Period match: 0,1,2 then wrap, interrupt one cycle after status
		wr(stmr_pkg::OFS_COUNT, 32'h0);
		wr(stmr_pkg::OFS_PERIOD, 32'h2);
		wr(stmr_pkg::OFS_ENABLE, 32'h1);
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (irq !== 1'b1 && k < 50);
		if (k >= 50) hang;
		check(32'(k), 32'h6);
		wr(stmr_pkg::OFS_CONTROL, 32'h0);
		rd(stmr_pkg::OFS_STATUS, 32'h1, 32'h1);
		wr(stmr_pkg::OFS_CLEAR, 32'h1);
		cyc(2);
		check({31'h0, irq}, 32'h0);
		wr(stmr_pkg::OFS_ENABLE, 32'h0);
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		cyc(10);
		wr(stmr_pkg::OFS_CONTROL, 32'h0);
		check({31'h0, irq}, 32'h0);
		rd(stmr_pkg::OFS_STATUS, 32'h1, 32'h1);
		wr(stmr_pkg::OFS_CLEAR, 32'h3);
		$display("done: period match");
		// Each ratio runs about 5.5 prescaled ticks; count must land in 4..7
		wr(stmr_pkg::OFS_PERIOD, 32'hffff);
		for (int i = 0; i < 4; i++) begin
			r = (i == 3) ? 256 : (1 << (3 * i));
			wr(stmr_pkg::OFS_COUNT, 32'h0);
			wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b0, i[1:0], 1'b0, 1'b0));
			cyc((11 * r + 1) / 2 - 2);
			wr(stmr_pkg::OFS_CONTROL, 32'h0);
			rd(stmr_pkg::OFS_COUNT, 32'h4, 32'hfffc);
		end
		$display("done: prescale");
		// Idle stop holds the count; without it the count runs on
		wr(stmr_pkg::OFS_COUNT, 32'h0);
		idle <= 1'b1;
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
		cyc(20);
		rd(stmr_pkg::OFS_COUNT, 32'h0, '1);
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		cyc(20);
		wr(stmr_pkg::OFS_CONTROL, 32'h0);
		idle <= 1'b0;
		rd(stmr_pkg::OFS_COUNT, 32'h10, 32'hfff0);
		$display("done: idle");
		// Gated accumulation and the event on the gate's fall
		wr(stmr_pkg::OFS_COUNT, 32'h0);
		wr(stmr_pkg::OFS_ENABLE, 32'h2);
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0));
		cyc(20);
		rd(stmr_pkg::OFS_COUNT, 32'h0, '1);
		gate <= 1'b1;
		cyc(40);
		gate <= 1'b0;
		cyc(10);
		check({31'h0, irq}, 32'h1);
		rd(stmr_pkg::OFS_COUNT, 32'h20, 32'hffe0);
		rd(stmr_pkg::OFS_STATUS, 32'h2, 32'h2);
		wr(stmr_pkg::OFS_CONTROL, 32'h0);
		wr(stmr_pkg::OFS_CLEAR, 32'h3);
		wr(stmr_pkg::OFS_COUNT, 32'h0);
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b1));
		pulses(8'h05, 16'h0003);
		rd(stmr_pkg::OFS_COUNT, 32'h5, '1);
		$display("done: gate");
		// External pin, unsynchronised then synchronised, random burst length
		for (int s = 0; s < 2; s++) begin
			v = 32'(1 + ($random(seed) & 7));
			wr(stmr_pkg::OFS_COUNT, 32'h0);
			wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b0, 2'h0, s[0], 1'b1));
			cyc(30);
			rd(stmr_pkg::OFS_COUNT, 32'h0, '1);
			pulses(v[7:0], 16'(2 + ($random(seed) & 3)));
			rd(stmr_pkg::OFS_COUNT, v, '1);
		end
		wr(stmr_pkg::OFS_COUNT, 32'h0);
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1));
		pulses(8'h10, 16'h0002);
		rd(stmr_pkg::OFS_COUNT, 32'h2, '1);
		wr(stmr_pkg::OFS_COUNT, 32'h0);
		wr(stmr_pkg::OFS_CONTROL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
		pulses(8'h03, 16'(stmr_pkg::XTAL_PERIOD_CYC / 2));
		rd(stmr_pkg::OFS_COUNT, 32'h3, '1);
		$display("done: external");
		final_report;
	end
endmodule
